/* design/sac_consts.vh */
/*
  constants for the converter sequencing and readout block: register
  offsets, control field positions, reset values and cycle counts.
  assumes a 125 MHz clock (8 ns period); times are in picoseconds.
*/
// What this block does
// - busy rises within 30 ns of the convert strobe falling
// - busy high at most 0.75/1/1.25 us outside master read-after mode
// - conversion finishes within 0.75/1/1.25 us for fast/normal/reduced power
// - busy stays high at least 10 ns after internal end of conversion
// - parallel result valid within 0.75/1/1.25 us of convert strobe falling
// - parallel result valid at least 20 ns before busy falls
// - read during conversion: frame strobe within 25 ns of convert strobe
// - read after conversion: first clock edge 4 ns or 20 ns after frame
// - master clock period at least 25/50/100/200 ns per divider setting
// - master clock period at most 40/70/140/280 ns per divider setting
// - frame held 3/60/140/300 ns after last clock edge per divider
// - fast mode read-after busy at most 1.5/2/3/5.25 us per divider
// - normal mode read-after busy at most 1.75/2.25/3.25/5.5 us
// - reduced power read-after busy at most 2/2.5/3.5/5.75 us
// - read after conversion: busy falls about 25 ns after frame ends
// - chip select high releases serial outputs within 10 ns; low drives
// - slave serial data updates 3 to 16 ns after host clock edge
`ifndef SAC_CONSTS_VH
`define SAC_CONSTS_VH

`define SAC_CLK_PS 8000

// register offsets
`define SAC_OFF_CTRL 2'h0
`define SAC_OFF_STAT 2'h1
`define SAC_OFF_RES 2'h2

// control register fields
`define SAC_CTRL_FAST 0
`define SAC_CTRL_LOWPWR 1
`define SAC_CTRL_SERIAL 2
`define SAC_CTRL_MASTER 3
`define SAC_CTRL_AFTER 4
`define SAC_CTRL_DIV_LO 5
`define SAC_CTRL_DIV_HI 6
`define SAC_CTRL_RST 8'h00

// conversion and busy timing
`define SAC_T_CONV_FAST_PS 750000
`define SAC_T_CONV_NORM_PS 1000000
`define SAC_T_CONV_LOWP_PS 1250000
`define SAC_T_EOC_BUSY_PS 10000
`define SAC_T_DV_BUSY_PS 20000
`define SAC_T_SYNC_BUSY_PS 25000
`define SAC_CONV_FAST_CYC (`SAC_T_CONV_FAST_PS / `SAC_CLK_PS)
`define SAC_CONV_NORM_CYC (`SAC_T_CONV_NORM_PS / `SAC_CLK_PS)
`define SAC_CONV_LOWP_CYC (`SAC_T_CONV_LOWP_PS / `SAC_CLK_PS)
`define SAC_EOC_BUSY_CYC ((`SAC_T_EOC_BUSY_PS + `SAC_CLK_PS - 1) / `SAC_CLK_PS)
`define SAC_DV_BUSY_CYC ((`SAC_T_DV_BUSY_PS + `SAC_CLK_PS - 1) / `SAC_CLK_PS)
`define SAC_SYNC_BUSY_CYC (`SAC_T_SYNC_BUSY_PS / `SAC_CLK_PS)

// master serial clock timing per divider setting
`define SAC_T_PER0_PS 25000
`define SAC_T_PER1_PS 50000
`define SAC_T_PER2_PS 100000
`define SAC_T_PER3_PS 200000
`define SAC_T_LEAD0_PS 4000
`define SAC_T_LEAD1_PS 20000
`define SAC_T_TAIL0_PS 3000
`define SAC_T_TAIL1_PS 60000
`define SAC_T_TAIL2_PS 140000
`define SAC_T_TAIL3_PS 300000
`define SAC_CEIL(t) (((t) + `SAC_CLK_PS - 1) / `SAC_CLK_PS)

`endif

/* design/sac_mser.v */
/*
  master serial shifter: frame strobe, internal serial clock and data
  for one 16-bit word, msb first, data changing on the falling edge.
  assumes start is a one-cycle pulse given only while idle.
*/
`timescale 1ns/1ps
`include "sac_consts.vh"

module sac_mser (
  // clock and reset
  input wire clk,
  input wire rst,
  // transfer request
  input wire start,
  input wire [1:0] div,
  input wire [15:0] word,
  // serial lines
  output reg sync_reg,
  output reg sclk_reg,
  output reg sdo_reg,
  output reg done_reg
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_LEAD = 2'h1;
  localparam [1:0] ST_SHIFT = 2'h2;
  localparam [1:0] ST_TAIL = 2'h3;

  // cycle counts stay below 64, so the cut to counter width loses nothing
  function [5:0] to6;
    input integer n;
    to6 = n[5:0];
  endfunction

  localparam [5:0] PER0 = to6(`SAC_CEIL(`SAC_T_PER0_PS));
  localparam [5:0] PER1 = to6(`SAC_CEIL(`SAC_T_PER1_PS));
  localparam [5:0] PER2 = to6(`SAC_CEIL(`SAC_T_PER2_PS));
  localparam [5:0] PER3 = to6(`SAC_CEIL(`SAC_T_PER3_PS));
  localparam [5:0] LEAD0 = to6(`SAC_CEIL(`SAC_T_LEAD0_PS));
  localparam [5:0] LEAD1 = to6(`SAC_CEIL(`SAC_T_LEAD1_PS));
  localparam [5:0] TAIL0 = to6(`SAC_CEIL(`SAC_T_TAIL0_PS));
  localparam [5:0] TAIL1 = to6(`SAC_CEIL(`SAC_T_TAIL1_PS));
  localparam [5:0] TAIL2 = to6(`SAC_CEIL(`SAC_T_TAIL2_PS));
  localparam [5:0] TAIL3 = to6(`SAC_CEIL(`SAC_T_TAIL3_PS));

  // pick one of four figures by divider setting
  function [5:0] sel4;
    input [1:0] d;
    input [5:0] a;
    input [5:0] b;
    input [5:0] c;
    input [5:0] e;
    begin
      case (d)
        2'h0: sel4 = a;
        2'h1: sel4 = b;
        2'h2: sel4 = c;
        default: sel4 = e;
      endcase
    end
  endfunction

  reg [1:0] state_reg;
  reg [1:0] div_reg;
  reg [15:0] sh_reg;
  reg [3:0] bit_reg;
  reg [5:0] cnt_reg;
  wire [5:0] per;
  wire [5:0] fall_at;

  assign per = sel4(div_reg, PER0, PER1, PER2, PER3);
  // high phase takes the odd cycle so the high time is the longer one
  assign fall_at = per - {1'b0, per[5:1]} - 6'h01;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      div_reg <= 2'h0;
      sh_reg <= 16'h0000;
      bit_reg <= 4'h0;
      cnt_reg <= 6'h00;
      sync_reg <= 1'b0;
      sclk_reg <= 1'b0;
      sdo_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (start)
          begin
            div_reg <= div;
            sh_reg <= word;
            sdo_reg <= word[15];
            sync_reg <= 1'b1;
            cnt_reg <= sel4(div, LEAD0, LEAD1, LEAD1, LEAD1) - 6'h01;
            state_reg <= ST_LEAD;
          end
        end
        ST_LEAD:
        begin
          if (cnt_reg == 6'h00)
          begin
            sclk_reg <= 1'b1;
            bit_reg <= 4'h0;
            state_reg <= ST_SHIFT;
          end
          else
            cnt_reg <= cnt_reg - 6'h01;
        end
        ST_SHIFT:
        begin
          if (cnt_reg == fall_at)
          begin
            sclk_reg <= 1'b0;
            sh_reg <= {sh_reg[14:0], 1'b0};
            sdo_reg <= sh_reg[14];
            if (bit_reg == 4'hf)
            begin
              cnt_reg <= sel4(div_reg, TAIL0, TAIL1, TAIL2, TAIL3) - 6'h01;
              state_reg <= ST_TAIL;
            end
            else
              cnt_reg <= cnt_reg + 6'h01;
          end
          else if (cnt_reg == per - 6'h01)
          begin
            sclk_reg <= 1'b1;
            cnt_reg <= 6'h00;
            bit_reg <= bit_reg + 4'h1;
          end
          else
            cnt_reg <= cnt_reg + 6'h01;
        end
        ST_TAIL:
        begin
          if (cnt_reg == 6'h00)
          begin
            sync_reg <= 1'b0;
            done_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
          else
            cnt_reg <= cnt_reg - 6'h01;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule // sac_mser

/* design/sac_top.v */
/*
  conversion sequencer and readout ports of the 16-bit converter:
  busy timing, result latch, parallel bus, master and slave serial port.
  assumes all pins synchronous to clk; the analog core presents its
  finished code on sample_code at the internal end of conversion.
*/
`timescale 1ns/1ps
`include "sac_consts.vh"

module sac_top (
  // clock and reset
  input wire clk,
  input wire rst,
  // register port
  input wire [1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [15:0] reg_rdata,
  // conversion control
  input wire convert_start_n,
  input wire cs_n,
  input wire [15:0] sample_code,
  output wire busy,
  // parallel port
  output wire [15:0] data_out,
  output wire data_oe_n,
  // serial port
  input wire ext_sclk,
  input wire serial_daisy_in,
  output wire sync_out,
  output wire sync_oe_n,
  output wire sclk_out,
  output wire sclk_oe_n,
  output wire serial_data_out,
  output wire serial_data_oe_n
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_CONV = 3'h1;
  localparam [2:0] ST_HOLD = 3'h2;
  localparam [2:0] ST_XFER = 3'h3;
  localparam [2:0] ST_DROP = 3'h4;

  localparam [1:0] MODE_NORM = 2'h0;
  localparam [1:0] MODE_FAST = 2'h1;
  localparam [1:0] MODE_LOWP = 2'h2;

  // cycle counts stay below 256, so the cut to counter width loses nothing
  function [7:0] to8;
    input integer n;
    to8 = n[7:0];
  endfunction

  // result must be valid before busy falls, which also covers eoc hold
  localparam [7:0] BUSY_TAIL = to8((`SAC_DV_BUSY_CYC > `SAC_EOC_BUSY_CYC) ?
    `SAC_DV_BUSY_CYC : `SAC_EOC_BUSY_CYC);
  localparam [7:0] SYNC_BUSY = to8(`SAC_SYNC_BUSY_CYC);
  localparam [7:0] CONV_FAST = to8(`SAC_CONV_FAST_CYC);
  localparam [7:0] CONV_NORM = to8(`SAC_CONV_NORM_CYC);
  localparam [7:0] CONV_LOWP = to8(`SAC_CONV_LOWP_CYC);

  // mode from the two select bits; both or neither give normal
  function [1:0] mode_of;
    input fast;
    input lowp;
    begin
      if (fast && !lowp)
        mode_of = MODE_FAST;
      else if (lowp && !fast)
        mode_of = MODE_LOWP;
      else
        mode_of = MODE_NORM;
    end
  endfunction

  // conversion count leaves room for the tail and the start edge
  function [7:0] conv_load;
    input [1:0] m;
    begin
      case (m)
        MODE_FAST: conv_load = CONV_FAST - BUSY_TAIL - 8'h01;
        MODE_LOWP: conv_load = CONV_LOWP - BUSY_TAIL - 8'h01;
        default: conv_load = CONV_NORM - BUSY_TAIL - 8'h01;
      endcase
    end
  endfunction

  reg [7:0] ctrl_reg;
  reg [2:0] state_reg;
  reg [7:0] cnt_reg;
  reg [1:0] mode_reg;
  reg after_reg;
  reg cnv_prev_reg;
  reg busy_reg;
  reg lost_reg;
  reg [15:0] result_reg;
  reg [15:0] data_reg;
  reg data_oe_n_reg;
  reg [15:0] slv_sh_reg;
  reg ext_prev_reg;
  reg sync_o_reg;
  reg sclk_o_reg;
  reg sdo_o_reg;
  reg sync_oe_n_reg;
  reg sclk_oe_n_reg;
  reg sdo_oe_n_reg;
  reg [15:0] rdata_reg;
  reg [15:0] rdata_next;

  wire cnv_fall;
  wire start;
  wire eoc;
  wire ser_en;
  wire mst_en;
  wire aft_en;
  wire mst_start;
  wire [15:0] mst_word;
  wire [1:0] mst_div;
  wire mst_sync;
  wire mst_sclk;
  wire mst_sdo;
  wire mst_done;
  wire ext_rise;

  assign ser_en = ctrl_reg[`SAC_CTRL_SERIAL];
  assign mst_en = ctrl_reg[`SAC_CTRL_MASTER];
  assign aft_en = ctrl_reg[`SAC_CTRL_AFTER];

  assign cnv_fall = cnv_prev_reg && !convert_start_n;
  // a strobe while a conversion runs is dropped, never restarts it
  assign start = cnv_fall && (state_reg == ST_IDLE);
  assign eoc = (state_reg == ST_CONV) && (cnt_reg == 8'h00);

  // read during conversion ships the previous word at divider 00,
  // read after conversion ships the new word once it is latched
  assign mst_start = ser_en && mst_en &&
    ((start && !aft_en) || (eoc && after_reg));
  assign mst_word = eoc ? sample_code : result_reg;
  assign mst_div = eoc ? ctrl_reg[`SAC_CTRL_DIV_HI:`SAC_CTRL_DIV_LO] : 2'h0;

  sac_mser u_mser (
    .clk(clk),
    .rst(rst),
    .start(mst_start),
    .div(mst_div),
    .word(mst_word),
    .sync_reg(mst_sync),
    .sclk_reg(mst_sclk),
    .sdo_reg(mst_sdo),
    .done_reg(mst_done)
  );

  // conversion sequencing
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 8'h00;
      mode_reg <= MODE_NORM;
      after_reg <= 1'b0;
      cnv_prev_reg <= 1'b1;
      busy_reg <= 1'b0;
      result_reg <= 16'h0000;
    end
    else
    begin
      cnv_prev_reg <= convert_start_n;
      case (state_reg)
        ST_IDLE:
        begin
          if (start)
          begin
            busy_reg <= 1'b1;
            mode_reg <= mode_of(ctrl_reg[`SAC_CTRL_FAST], ctrl_reg[`SAC_CTRL_LOWPWR]);
            after_reg <= ser_en && mst_en && aft_en;
            cnt_reg <= conv_load(mode_of(ctrl_reg[`SAC_CTRL_FAST],
              ctrl_reg[`SAC_CTRL_LOWPWR]));
            state_reg <= ST_CONV;
          end
        end
        ST_CONV:
        begin
          if (cnt_reg == 8'h00)
          begin
            result_reg <= sample_code;
            if (after_reg)
              state_reg <= ST_XFER;
            else
            begin
              cnt_reg <= BUSY_TAIL - 8'h01;
              state_reg <= ST_HOLD;
            end
          end
          else
            cnt_reg <= cnt_reg - 8'h01;
        end
        ST_HOLD:
        begin
          if (cnt_reg == 8'h00)
          begin
            busy_reg <= 1'b0;
            state_reg <= ST_IDLE;
          end
          else
            cnt_reg <= cnt_reg - 8'h01;
        end
        ST_XFER:
        begin
          // word length and divider bound the busy time in this mode
          if (mst_done)
          begin
            cnt_reg <= SYNC_BUSY - 8'h01;
            state_reg <= ST_DROP;
          end
        end
        ST_DROP:
        begin
          if (cnt_reg == 8'h00)
          begin
            busy_reg <= 1'b0;
            state_reg <= ST_IDLE;
          end
          else
            cnt_reg <= cnt_reg - 8'h01;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // parallel result and slave shifter
  assign ext_rise = !ext_prev_reg && ext_sclk;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      data_reg <= 16'h0000;
      data_oe_n_reg <= 1'b1;
      slv_sh_reg <= 16'h0000;
      ext_prev_reg <= 1'b0;
    end
    else
    begin
      ext_prev_reg <= ext_sclk;
      data_oe_n_reg <= cs_n || ser_en;
      if (eoc)
      begin
        data_reg <= sample_code;
        slv_sh_reg <= sample_code;
      end
      else if (ext_rise && !cs_n && ser_en && !mst_en)
        slv_sh_reg <= {slv_sh_reg[14:0], serial_daisy_in};
    end
  end

  // serial output stage; one flop for every pin and its enable
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync_o_reg <= 1'b0;
      sclk_o_reg <= 1'b0;
      sdo_o_reg <= 1'b0;
      sync_oe_n_reg <= 1'b1;
      sclk_oe_n_reg <= 1'b1;
      sdo_oe_n_reg <= 1'b1;
    end
    else
    begin
      sync_o_reg <= mst_en && mst_sync;
      sclk_o_reg <= mst_en && mst_sclk;
      sdo_o_reg <= mst_en ? mst_sdo : slv_sh_reg[15];
      sync_oe_n_reg <= cs_n || !ser_en || !mst_en;
      sclk_oe_n_reg <= cs_n || !ser_en || !mst_en;
      sdo_oe_n_reg <= cs_n || !ser_en;
    end
  end

  // register port: control write, read data in the next cycle only
  always @*
  begin
    rdata_next = 16'h0000;
    if (reg_rd)
    begin
      case (reg_addr)
        `SAC_OFF_CTRL: rdata_next = {8'h00, ctrl_reg};
        `SAC_OFF_STAT: rdata_next = {10'h000, mode_reg, lost_reg, state_reg == ST_XFER,
          mst_sync, busy_reg};
        `SAC_OFF_RES: rdata_next = result_reg;
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= `SAC_CTRL_RST;
      lost_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end
    else
    begin
      rdata_reg <= rdata_next;
      if (reg_wr && reg_addr == `SAC_OFF_CTRL)
        ctrl_reg <= reg_wdata[7:0];
      // strobe ignored while busy; a new one beats the read that clears
      if (cnv_fall && state_reg != ST_IDLE)
        lost_reg <= 1'b1;
      else if (reg_rd && reg_addr == `SAC_OFF_STAT)
        lost_reg <= 1'b0;
    end
  end

  assign reg_rdata = rdata_reg;
  assign busy = busy_reg;
  assign data_out = data_reg;
  assign data_oe_n = data_oe_n_reg;
  assign sync_out = sync_o_reg;
  assign sync_oe_n = sync_oe_n_reg;
  assign sclk_out = sclk_o_reg;
  assign sclk_oe_n = sclk_oe_n_reg;
  assign serial_data_out = sdo_o_reg;
  assign serial_data_oe_n = sdo_oe_n_reg;

endmodule // sac_top

/* sim/sac_chk_sva.sv */
/*
  checker for the converter sequencer: busy, frame and serial clock timing.
  assumes a 125 MHz clk and control writes at register index 0.
*/
`timescale 1ns/1ps

module sac_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register writes
  input wire logic [1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  // conversion
  input wire logic convert_start_n,
  input wire logic cs_n,
  input wire logic busy,
  input wire logic [15:0] data_out,
  // serial port
  input wire logic sync_out,
  input wire logic sclk_out,
  input wire logic sync_oe_n,
  input wire logic sclk_oe_n,
  input wire logic serial_data_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // cycle bounds at 8 ns, indexed by divider, by mode or by {divider, mode}
  localparam int PMIN [4] = '{4, 7, 13, 25};
  localparam int PMAX [4] = '{5, 8, 17, 35};
  localparam int TMIN [4] = '{1, 8, 18, 38};
  localparam int BCNV [4] = '{125, 93, 156, 125};
  localparam int BAFT [16] = '{218, 187, 250, 218, 281, 250, 312, 281,
    406, 375, 437, 406, 687, 656, 718, 687};
  logic [7:0] ctrl_reg;
  logic [1:0] mode_reg, div_reg;
  logic after_reg, cnv_prev_reg, sclk_prev_reg, first_reg;
  logic [9:0] bcnt_reg, pcnt_reg, tcnt_reg;
  int lim;
  wire start_seen = cnv_prev_reg && !convert_start_n && !busy;
  wire sclk_rise = sclk_out && !sclk_prev_reg;
  always_comb lim = after_reg ? BAFT[{div_reg, mode_reg}] : BCNV[mode_reg];
  // divider shadow is taken at frame start, so a mid-word write must not move it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= 8'h00;
      mode_reg <= 2'h0;
      div_reg <= 2'h0;
      after_reg <= 1'b0;
      cnv_prev_reg <= 1'b1;
      sclk_prev_reg <= 1'b0;
      first_reg <= 1'b0;
      bcnt_reg <= 10'h000;
      pcnt_reg <= 10'h000;
      tcnt_reg <= 10'h000;
    end
    else
    begin
      cnv_prev_reg <= convert_start_n;
      sclk_prev_reg <= sclk_out;
      if (reg_wr && reg_addr == 2'h0) ctrl_reg <= reg_wdata[7:0];
      if (start_seen) mode_reg <= (ctrl_reg[1:0] == 2'h3) ? 2'h0 : ctrl_reg[1:0];
      if (start_seen) after_reg <= ctrl_reg[4:2] == 3'h7;
      if ($rose(sync_out)) div_reg <= after_reg ? ctrl_reg[6:5] : 2'h0;
      first_reg <= $rose(sync_out) ? 1'b1 : (sclk_rise ? 1'b0 : first_reg);
      bcnt_reg <= busy ? bcnt_reg + 10'h001 : 10'h000;
      pcnt_reg <= sclk_rise ? 10'h001 : pcnt_reg + {9'h000, pcnt_reg != 10'h3ff};
      tcnt_reg <= (sclk_out != sclk_prev_reg) ? 10'h001 : tcnt_reg + {9'h000, tcnt_reg != 10'h3ff};
    end
  end
  sequence sclk_quiet3;
    !sclk_out [*3];
  endsequence
  busy_rise_a:
    assert property (start_seen |-> ##[1:3] busy) else $error("busy late after strobe");
  busy_max_a:
    assert property (busy |-> bcnt_reg < lim) else $error("busy high too long");
  data_lead_a:
    assert property ($fell(busy) |-> data_out == $past(data_out, 3)) else $error("data late");
  sync_during_a:
    assert property (start_seen && ctrl_reg[4:2] == 3'h3 && !cs_n |-> ##[1:2] sync_out)
      else $error("frame late after strobe");
  lead_min_a:
    assert property ($rose(sync_out) |-> !sclk_out) else $error("clock edge with frame");
  lead_wide_a:
    assert property ($rose(sync_out) && after_reg && ctrl_reg[6:5] != 2'h0 |-> sclk_quiet3)
      else $error("first clock edge too early");
  sclk_period_a:
    assert property (sclk_rise && !first_reg |-> pcnt_reg >= PMIN[div_reg]
      && pcnt_reg <= PMAX[div_reg]) else $error("serial clock period out of range");
  sync_tail_a:
    assert property ($fell(sync_out) |-> tcnt_reg >= TMIN[div_reg]) else $error("frame cut short");
  busy_end_a:
    assert property ($fell(sync_out) && after_reg |-> ##[2:4] $fell(busy))
      else $error("busy fall not after frame");
  cs_release_a:
    assert property ($rose(cs_n) |=> sync_oe_n && sclk_oe_n && serial_data_oe_n)
      else $error("serial pins not released");
  cs_drive_a:
    assert property ($fell(cs_n) && ctrl_reg[2] |=> !serial_data_oe_n) else $error("data not driven");
endmodule // sac_chk

bind sac_top sac_chk chk_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .convert_start_n(convert_start_n), .cs_n(cs_n), .busy(busy),
  .data_out(data_out), .sync_out(sync_out), .sclk_out(sclk_out), .sync_oe_n(sync_oe_n),
  .sclk_oe_n(sclk_oe_n), .serial_data_oe_n(serial_data_oe_n));

/* sim/sac_host.sv */
/*
  host model: captures master frames, clocks slave reads on request.
  assumes pins sampled on clk; a released data line reads as the inverse of its last level, a released frame or clock reads low.
*/
`timescale 1ns/1ps

module sac_host (
  // clock
  input wire logic clk,
  // device serial pins
  input wire logic sync_out,
  input wire logic sync_oe_n,
  input wire logic sclk_out,
  input wire logic sclk_oe_n,
  input wire logic serial_data_out,
  input wire logic serial_data_oe_n,
  // host side
  input wire logic slave_go,
  output logic ext_sclk,
  output logic serial_daisy_in,
  output logic [15:0] rx_m,
  output logic [15:0] rx_s
);
  logic sdo_last = 1'b0;
  logic sclk_prev = 1'b0;
  wire sdo_w = serial_data_oe_n ? ~sdo_last : serial_data_out;
  wire sclk_w = !sclk_oe_n && sclk_out;
  wire sync_w = !sync_oe_n && sync_out;
  always @(posedge clk)
  begin
    sdo_last <= sdo_w;
    sclk_prev <= sclk_w;
    if (sync_w && sclk_w && !sclk_prev) rx_m <= {rx_m[14:0], sdo_w};
  end
  // slave clock stands low between words; 2 high, 3 low covers the output delay
  initial
  begin
    ext_sclk = 1'b0;
    serial_daisy_in = 1'b0;
    rx_s = 16'h0000;
    forever
    begin
      @(posedge clk);
      if (slave_go)
      begin
        repeat (16)
        begin
          rx_s <= {rx_s[14:0], sdo_w};
          serial_daisy_in <= ~serial_daisy_in;
          ext_sclk <= 1'b1;
          repeat (2) @(posedge clk);
          ext_sclk <= 1'b0;
          repeat (3) @(posedge clk);
        end
      end
    end
  end
endmodule // sac_host

/* sim/tb_top.sv */
/*
  testbench: register port, conversions in every mode, serial readout.
  assumes the host model clocks slave reads when asked.
*/
`timescale 1ns/1ps

module tb_top;
  logic clk, rst, reg_wr, reg_rd, convert_start_n, cs_n, slave_go;
  logic [1:0] reg_addr;
  logic [15:0] reg_wdata, sample_code, q, code;
  wire [15:0] reg_rdata, data_out, rx_m, rx_s;
  wire busy, data_oe_n, ext_sclk, serial_daisy_in, sync_out, sync_oe_n;
  wire sclk_out, sclk_oe_n, serial_data_out, serial_data_oe_n;
  int mismatches, n_compared, w;
  int lim [4] = '{125, 93, 156, 125};
  int alim [4] = '{187, 281, 437, 687};
  logic [1:0] md [4] = '{2'h0, 2'h1, 2'h2, 2'h0};

  sac_top dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .convert_start_n(convert_start_n),
    .cs_n(cs_n), .sample_code(sample_code), .busy(busy), .data_out(data_out),
    .data_oe_n(data_oe_n), .ext_sclk(ext_sclk), .serial_daisy_in(serial_daisy_in),
    .sync_out(sync_out), .sync_oe_n(sync_oe_n), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n),
    .serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n));
  sac_host host_u (.clk(clk), .sync_out(sync_out), .sync_oe_n(sync_oe_n), .sclk_out(sclk_out),
    .sclk_oe_n(sclk_oe_n), .serial_data_out(serial_data_out),
    .serial_data_oe_n(serial_data_oe_n), .slave_go(slave_go), .ext_sclk(ext_sclk),
    .serial_daisy_in(serial_daisy_in), .rx_m(rx_m), .rx_s(rx_s));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // strobe, then count busy cycles until it falls; with dup a second strobe comes while busy is high
  task automatic conv(input logic [15:0] cd, input int at, input logic [15:0] midv,
      input bit dup, output int n);
    @(posedge clk);
    sample_code <= cd;
    convert_start_n <= 1'b0;
    reg_addr <= 2'h0;
    n = 0;
    for (int i = 0; i < 2000; i++)
    begin
      @(posedge clk);
      convert_start_n <= !(i < 2 || (dup && i >= 20 && i < 22));
      reg_wdata <= midv;
      reg_wr <= (at != 0 && i == at);
      #1;
      if (busy === 1'b1) n++;
      else if (n > 0) break;
    end
  endtask
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // whole run is near 2300 cycles; this allows over ten times that
  initial
  begin
    #200000;
    mismatches++;
    tally_and_finish;
  end
  initial
  begin
    mismatches = 0;
    n_compared = 0;
    rst = 1'b1;
    {reg_wr, reg_rd, slave_go, cs_n} = 4'h0;
    convert_start_n = 1'b1;
    reg_addr = 2'h0;
    reg_wdata = 16'h0000;
    sample_code = 16'h0000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(2'h0, q);
    chk("ctrl reset", 16'h0000, q);
    rd(2'h1, q);
    chk("stat reset", 16'h0000, q & 16'h003f);
    rd(2'h3, q);
    chk("unmapped", 16'h0000, q);
    wr(2'h2, 16'h1234);
    rd(2'h2, q);
    chk("result ro", 16'h0000, q);
    wr(2'h0, 16'hffff);
    rd(2'h0, q);
    chk("ctrl rw", 16'h00ff, q);
    for (int m = 0; m < 4; m++)
    begin
      code = 16'h8001 + 16'(m) * 16'h1111;
      wr(2'h0, 16'(m));
      conv(code, 0, 16'h0000, m == 3, w);
      chk("busy width", 16'h0001, {15'h0, w <= lim[m]});
      chk("parallel data", code, data_out);
      rd(2'h2, q);
      chk("result", code, q);
      rd(2'h1, q);
      chk("stat lost", {10'h0, md[m], m == 3, 3'h0}, q & 16'h003f);
      rd(2'h1, q);
      chk("stat clear", {10'h0, md[m], 4'h0}, q & 16'h003f);
    end
    wr(2'h0, 16'h000c);
    conv(16'h0f0f, 0, 16'h000c, 1'b0, w);
    chk("read during", 16'hb334, rx_m);
    for (int d = 0; d < 4; d++)
    begin
      code = 16'hc3a5 ^ 16'(d);
      wr(2'h0, 16'h001c | 16'(d << 5) | {14'h0, d == 2, d == 0});
      conv(code, d == 3 ? 200 : 0, 16'h001c, 1'b0, w);
      chk("read after", code, rx_m);
      chk("after busy", 16'h0001, {15'h0, w <= alim[d]});
    end
    wr(2'h0, 16'h000c);
    @(posedge clk);
    cs_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("oe off", 16'h000f, {12'h0, data_oe_n, sync_oe_n, sclk_oe_n, serial_data_oe_n});
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("oe on", 16'h0008, {12'h0, data_oe_n, sync_oe_n, sclk_oe_n, serial_data_oe_n});
    wr(2'h0, 16'h0004);
    conv(16'h5a3c, 0, 16'h0004, 1'b0, w);
    @(posedge clk);
    slave_go <= 1'b1;
    @(posedge clk);
    slave_go <= 1'b0;
    repeat (90) @(posedge clk);
    chk("slave word", 16'h5a3c, rx_s);
    tally_and_finish;
  end
endmodule // tb_top
